//--- hw/kwdt_pkg.sv
// Constants, field layouts and carrier types of the keyed watchdog timer.
// Assumes a single 20 MHz clock and a plain register port with 8-bit byte addresses.
package kwdt_pkg;

    // ==========================================================
    // Register offsets
    localparam logic [7:0] OFF_OVERFLOW_MODE   = 8'h00;
    localparam logic [7:0] OFF_CLOCK_MODE      = 8'h04;
    localparam logic [7:0] OFF_RESTART_CONTROL = 8'h08;
    localparam logic [7:0] OFF_EXPIRY_STATUS   = 8'h0c;
    localparam logic [7:0] OFF_IRQ_STATUS      = 8'h10;
    localparam logic [7:0] OFF_IRQ_MASK        = 8'h14;

    // ==========================================================
    // Field positions
    localparam int MODE_FIELD_MSB     = 3;
    localparam int MODE_KEY_LSB       = 4;
    localparam int MODE_KEY_MSB       = 15;
    localparam int CLOCKCFG_FIELD_MSB = 5;
    localparam int CLOCKCFG_KEY_LSB   = 7;
    localparam int CLOCKCFG_KEY_MSB   = 15;
    localparam int RESTART_KEY_MSB    = 15;
    localparam int EXPIRY_FLAG_BIT    = 0;
    localparam int EVT_EXPIRY         = 0;
    localparam int EVT_KEY_FAULT      = 1;
    localparam int EVT_W              = 2;

    // ==========================================================
    // Access keys and reset values
    localparam logic [11:0] MODE_WRITE_KEY     = 12'h234;
    localparam logic [8:0]  CLOCKCFG_WRITE_KEY = 9'h06e;
    localparam logic [15:0] RESTART_KEY        = 16'hc071;
    localparam logic [3:0]  OVERFLOW_MODE_RST  = 4'h0;
    localparam logic [5:0]  CLOCK_MODE_RST     = 6'h00;
    localparam logic [11:0] PRELOAD_LOW_ONES   = 12'hfff;

    // ==========================================================
    // Timing counts in master clock cycles
    localparam logic [12:0] DIV_SEL0         = 13'h0020;
    localparam logic [12:0] DIV_SEL1         = 13'h0080;
    localparam logic [12:0] DIV_SEL2         = 13'h0400;
    localparam logic [12:0] DIV_SEL3         = 13'h1000;
    localparam logic [3:0]  PIN_PULSE_CYCLES = 4'h8;

    // ==========================================================
    // Carrier types
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } kwdt_bus_req_t;

    typedef struct packed {
        logic pin_pulse_on_expiry;
        logic interrupt_on_expiry;
        logic reset_on_expiry;
        logic dog_enable;
    } kwdt_mode_t;

    typedef struct packed {
        logic [3:0] preload_high_nibble;
        logic [1:0] tick_divider_select;
    } kwdt_clkcfg_t;

endpackage : kwdt_pkg

//--- hw/kwdt_prescaler.sv
// Divider that turns the master clock into the watchdog counting tick.
// Assumes sel is held steady by the register file; clear restarts the phase.
`timescale 1ns/1ns
module kwdt_prescaler (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Control
    input  wire logic       clear,
    input  wire logic [1:0] sel,
    // Tick out
    output logic            tick
);
    logic [11:0] cnt_reg;
    logic [11:0] cnt_next;
    logic        tick_next;

    // Wrap mask of the selected division
    function automatic logic [11:0] div_mask(input logic [1:0] s);
        logic [12:0] d;
        d = kwdt_pkg::DIV_SEL0;
        case (s)
            2'h1: d = kwdt_pkg::DIV_SEL1;
            2'h2: d = kwdt_pkg::DIV_SEL2;
            2'h3: d = kwdt_pkg::DIV_SEL3;
            default: d = kwdt_pkg::DIV_SEL0;
        endcase
        div_mask = 12'(d - 13'h0001);
    endfunction : div_mask

    // ==========================================================
    // Free running phase counter, one tick per wrap
    always_comb begin
        cnt_next  = clear ? 12'h000 : 12'(cnt_reg + 12'h001);
        tick_next = !clear && ((cnt_reg & div_mask(sel)) == div_mask(sel)); // RULE2
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_reg <= 12'h000;
            tick    <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            tick    <= tick_next;
        end
    end

    a_tick_gap: assert property (@(posedge clk) disable iff (rst)
        tick |=> (!tick)[*8]) else $error("tick too close"); // RULE2

endmodule : kwdt_prescaler

//--- hw/kwdt_pin_pulse.sv
// Active-low pulse of a fixed width on the expiry pin.
// Assumes start is a one-cycle pulse; a new start restarts the width.
`timescale 1ns/1ns
module kwdt_pin_pulse (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Trigger
    input  wire logic start,
    // Pin
    output logic      pin_n
);
    logic [3:0] cnt_reg;
    logic [3:0] cnt_next;

    // ==========================================================
    // Width counter, pin low while nonzero
    always_comb begin
        cnt_next = cnt_reg;
        if (start) begin
            cnt_next = kwdt_pkg::PIN_PULSE_CYCLES; // RULE7
        end else if (cnt_reg != 4'h0) begin
            cnt_next = 4'(cnt_reg - 4'h1);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_reg <= 4'h0;
            pin_n   <= 1'b1;
        end else begin
            cnt_reg <= cnt_next;
            pin_n   <= (cnt_next == 4'h0);
        end
    end

    sequence seq_pin_low;
        (!pin_n)[*8];
    endsequence

    sequence seq_pin_release;
        pin_n;
    endsequence

    a_pin_width: assert property (@(posedge clk) disable iff (rst)
        start |=> seq_pin_low ##1 seq_pin_release) else $error("pin pulse not 8 cycles"); // RULE7

endmodule : kwdt_pin_pulse

//--- hw/kwdt_top.sv
// Keyed watchdog timer: registers, down counter, expiry outputs and interrupt.
// Assumes one 20 MHz clock, synchronous reset, and a register master that
// issues one-cycle read or write strobes and never waits.
//
// What this block does
// RULE1: 16-bit counter decrements on each enabled tick
// RULE2: Tick divider select picks /32 /128 /1024 /4096
// RULE3: Restart loads low twelve ones, high preload nibble
// RULE4: Disabled gives no outputs; enabled gives selected ones
// RULE5: Expiry with reset enable requests system reset
// RULE6: Expiry with interrupt enable pulses interrupt once
// RULE7: Expiry with pin enable drives pin low 8
// RULE8: Mode write needs key 0x234, reads zero
// RULE9: Clock write needs key 0x06E, reads zero
// RULE10: Software writes key with data, same access
// RULE11: Software restarts periodically before expiry
// RULE12: Mode, clock, restart, status at 0,4,8,C
// RULE13: Restart key 0xC071 reloads, others ignored
// RULE14: Expiry flag sticky until restart or reset
// RULE15: Mode bits enable, reset, irq, pin, key
// RULE16: Clock select, preload, key; expiry at zero
`timescale 1ns/1ns
module kwdt_top (
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   rst,
    // Register port
    input  wire kwdt_pkg::kwdt_bus_req_t bus_req,
    output logic [31:0]                 rd_data,
    // Expiry outputs
    output logic                        expiry_internal_reset,
    output logic                        expiry_irq_pulse,
    output logic                        expiry_pin_n,
    // Level interrupt
    output logic                        irq
);
    // ==========================================================
    // Declarations
    kwdt_pkg::kwdt_mode_t   mode_reg;
    kwdt_pkg::kwdt_mode_t   mode_next;
    kwdt_pkg::kwdt_clkcfg_t clkcfg_reg;
    kwdt_pkg::kwdt_clkcfg_t clkcfg_next;
    logic [15:0]            count_reg;
    logic [15:0]            count_next;
    logic                   expiry_flag_reg;
    logic                   expiry_flag_next;
    logic [1:0]             irq_status_reg;
    logic [1:0]             irq_status_next;
    logic [1:0]             irq_mask_reg;
    logic [1:0]             irq_mask_next;
    logic [31:0]            rd_data_next;
    logic                   rst_req_next;
    logic                   irq_pulse_next;
    logic                   pin_start_reg;
    logic                   pin_start_next;
    logic                   irq_next;
    logic                   tick;
    logic                   wr_mode;
    logic                   wr_clk;
    logic                   wr_restart;
    logic                   wr_irq_status;
    logic                   wr_irq_mask;
    logic                   mode_key_ok;
    logic                   clk_key_ok;
    logic                   restart;
    logic                   expire;
    logic [1:0]             events;

    // Counter value loaded on restart
    function automatic logic [15:0] preload(input logic [3:0] high);
        preload = {high, kwdt_pkg::PRELOAD_LOW_ONES};
    endfunction : preload

    // ==========================================================
    // Tick divider and pin pulse
    kwdt_prescaler u_prescaler (
        .clk   (clk),
        .rst   (rst),
        .clear (restart),
        .sel   (clkcfg_reg.tick_divider_select),
        .tick  (tick)
    );

    kwdt_pin_pulse u_pin_pulse (
        .clk   (clk),
        .rst   (rst),
        .start (pin_start_reg),
        .pin_n (expiry_pin_n)
    );

    // ==========================================================
    // Write decode and key checks
    always_comb begin
        wr_mode       = 1'b0;
        wr_clk        = 1'b0;
        wr_restart    = 1'b0;
        wr_irq_status = 1'b0;
        wr_irq_mask   = 1'b0;
        if (bus_req.wr && bus_req.addr == kwdt_pkg::OFF_OVERFLOW_MODE) begin // RULE12
            wr_mode = 1'b1;
        end else if (bus_req.wr && bus_req.addr == kwdt_pkg::OFF_CLOCK_MODE) begin
            wr_clk = 1'b1;
        end else if (bus_req.wr && bus_req.addr == kwdt_pkg::OFF_RESTART_CONTROL) begin
            wr_restart = 1'b1;
        end else if (bus_req.wr && bus_req.addr == kwdt_pkg::OFF_IRQ_STATUS) begin
            wr_irq_status = 1'b1;
        end else if (bus_req.wr && bus_req.addr == kwdt_pkg::OFF_IRQ_MASK) begin
            wr_irq_mask = 1'b1;
        end
        mode_key_ok = bus_req.wdata[kwdt_pkg::MODE_KEY_MSB:kwdt_pkg::MODE_KEY_LSB]
                      == kwdt_pkg::MODE_WRITE_KEY; // RULE8
        clk_key_ok  = bus_req.wdata[kwdt_pkg::CLOCKCFG_KEY_MSB:kwdt_pkg::CLOCKCFG_KEY_LSB]
                      == kwdt_pkg::CLOCKCFG_WRITE_KEY; // RULE9
        restart     = wr_restart
                      && bus_req.wdata[kwdt_pkg::RESTART_KEY_MSB:0] == kwdt_pkg::RESTART_KEY; // RULE13
    end

    // ==========================================================
    // Mode and clock configuration, updated only with the right key
    always_comb begin
        mode_next   = mode_reg;
        clkcfg_next = clkcfg_reg;
        if (wr_mode && mode_key_ok) begin
            mode_next = kwdt_pkg::kwdt_mode_t'(bus_req.wdata[kwdt_pkg::MODE_FIELD_MSB:0]); // RULE8 RULE15
        end
        if (wr_clk && clk_key_ok) begin
            clkcfg_next = kwdt_pkg::kwdt_clkcfg_t'(bus_req.wdata[kwdt_pkg::CLOCKCFG_FIELD_MSB:0]); // RULE9 RULE16
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            mode_reg   <= kwdt_pkg::kwdt_mode_t'(kwdt_pkg::OVERFLOW_MODE_RST);
            clkcfg_reg <= kwdt_pkg::kwdt_clkcfg_t'(kwdt_pkg::CLOCK_MODE_RST);
        end else begin
            mode_reg   <= mode_next;
            clkcfg_reg <= clkcfg_next;
        end
    end

    // ==========================================================
    // Down counter; a restart in the same cycle as the last tick wins
    always_comb begin
        expire     = tick && mode_reg.dog_enable && count_reg == 16'h0001 && !restart; // RULE16
        count_next = count_reg;
        if (restart) begin
            count_next = preload(clkcfg_reg.preload_high_nibble); // RULE3
        end else if (tick && mode_reg.dog_enable && count_reg != 16'h0000) begin
            count_next = 16'(count_reg - 16'h0001); // RULE1
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            count_reg <= preload(kwdt_pkg::CLOCK_MODE_RST[5:2]);
        end else begin
            count_reg <= count_next;
        end
    end

    // ==========================================================
    // Expiry flag, event status and mask
    always_comb begin
        expiry_flag_next = expiry_flag_reg;
        if (expire) begin
            expiry_flag_next = 1'b1; // RULE14
        end else if (restart) begin
            expiry_flag_next = 1'b0;
        end
        events                      = 2'h0;
        events[kwdt_pkg::EVT_EXPIRY] = expire;
        events[kwdt_pkg::EVT_KEY_FAULT] = (wr_mode && !mode_key_ok) || (wr_clk && !clk_key_ok);
        irq_status_next = irq_status_reg;
        if (wr_irq_status) begin
            irq_status_next = irq_status_reg & ~bus_req.wdata[kwdt_pkg::EVT_W-1:0];
        end
        irq_status_next = irq_status_next | events; // Set beats clear
        irq_mask_next   = wr_irq_mask ? bus_req.wdata[kwdt_pkg::EVT_W-1:0] : irq_mask_reg;
        irq_next        = |(irq_status_next & irq_mask_next);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            expiry_flag_reg <= 1'b0;
            irq_status_reg  <= 2'h0;
            irq_mask_reg    <= 2'h0;
            irq             <= 1'b0;
        end else begin
            expiry_flag_reg <= expiry_flag_next;
            irq_status_reg  <= irq_status_next;
            irq_mask_reg    <= irq_mask_next;
            irq             <= irq_next;
        end
    end

    // ==========================================================
    // Expiry outputs, each gated by its own enable
    always_comb begin
        rst_req_next   = expire && mode_reg.reset_on_expiry; // RULE4 RULE5
        irq_pulse_next = expire && mode_reg.interrupt_on_expiry; // RULE4 RULE6
        pin_start_next = expire && mode_reg.pin_pulse_on_expiry; // RULE4 RULE7
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            expiry_internal_reset <= 1'b0;
            expiry_irq_pulse      <= 1'b0;
            pin_start_reg         <= 1'b0;
        end else begin
            expiry_internal_reset <= rst_req_next;
            expiry_irq_pulse      <= irq_pulse_next;
            pin_start_reg         <= pin_start_next;
        end
    end

    // ==========================================================
    // Read data, valid only in the cycle after the strobe; keys read zero
    always_comb begin
        rd_data_next = 32'h0000_0000;
        if (!bus_req.rd) begin
            rd_data_next = 32'h0000_0000;
        end else if (bus_req.addr == kwdt_pkg::OFF_OVERFLOW_MODE) begin
            rd_data_next = {28'h000_0000, mode_reg}; // RULE8 RULE12
        end else if (bus_req.addr == kwdt_pkg::OFF_CLOCK_MODE) begin
            rd_data_next = {26'h0, clkcfg_reg}; // RULE9
        end else if (bus_req.addr == kwdt_pkg::OFF_EXPIRY_STATUS) begin
            rd_data_next[kwdt_pkg::EXPIRY_FLAG_BIT] = expiry_flag_reg; // RULE14
        end else if (bus_req.addr == kwdt_pkg::OFF_IRQ_STATUS) begin
            rd_data_next = {30'h0, irq_status_reg};
        end else if (bus_req.addr == kwdt_pkg::OFF_IRQ_MASK) begin
            rd_data_next = {30'h0, irq_mask_reg};
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rd_data <= 32'h0000_0000;
        end else begin
            rd_data <= rd_data_next;
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence seq_expire_event;
        tick && mode_reg.dog_enable && count_reg == 16'h0001 && !restart;
    endsequence

    a_count_decrement: assert property ( // RULE1
        tick && mode_reg.dog_enable && count_reg != 16'h0000 && !restart
        |=> count_reg == 16'($past(count_reg) - 16'h0001)) else $error("counter did not decrement");

    a_count_hold_off: assert property ( // RULE1
        !mode_reg.dog_enable && !restart |=> $stable(count_reg)) else $error("disabled counter moved");

    a_preload_value: assert property ( // RULE3
        restart |=> count_reg == {$past(clkcfg_reg.preload_high_nibble), 12'hfff})
        else $error("wrong preload");

    a_disabled_quiet: assert property ( // RULE4
        !mode_reg.dog_enable |=> !expiry_internal_reset && !expiry_irq_pulse && !pin_start_reg)
        else $error("output while disabled");

    a_reset_request: assert property ( // RULE5
        seq_expire_event ##0 mode_reg.reset_on_expiry |=> expiry_internal_reset)
        else $error("no reset request on expiry");

    a_irq_single: assert property ( // RULE6
        expiry_irq_pulse |-> $past(expire && mode_reg.interrupt_on_expiry) ##1 !expiry_irq_pulse)
        else $error("interrupt pulse not single");

    a_pin_follows: assert property ( // RULE7
        seq_expire_event ##0 mode_reg.pin_pulse_on_expiry |=> ##1 !expiry_pin_n)
        else $error("pin not driven on expiry");

    a_mode_key: assert property ( // RULE8
        wr_mode && !mode_key_ok |=> $stable(mode_reg)) else $error("mode changed without key");

    a_clock_key: assert property ( // RULE9
        wr_clk && !clk_key_ok |=> $stable(clkcfg_reg)) else $error("clock cfg changed without key");

    a_mode_readback: assert property ( // RULE12
        bus_req.rd && bus_req.addr == kwdt_pkg::OFF_OVERFLOW_MODE
        |=> rd_data == {28'h000_0000, $past(mode_reg)}) else $error("mode read wrong");

    a_restart_key: assert property ( // RULE13
        wr_restart && bus_req.wdata[15:0] != 16'hc071 && !tick |=> $stable(count_reg))
        else $error("bad key restarted counter");

    a_flag_sticky: assert property ( // RULE14
        expiry_flag_reg && !restart |=> expiry_flag_reg) else $error("expiry flag lost");

    a_expire_flag: assert property ( // RULE16
        seq_expire_event |=> expiry_flag_reg && count_reg == 16'h0000) else $error("expiry not seen");

    // Per-output gating
    a_reset_gate: assert property (!mode_reg.reset_on_expiry |=> !expiry_internal_reset) // RULE4
        else $error("reset not gated");

    a_irq_gate: assert property (!mode_reg.interrupt_on_expiry |=> !expiry_irq_pulse) // RULE4
        else $error("irq not gated");

    a_pin_gate: assert property (!mode_reg.pin_pulse_on_expiry |=> !pin_start_reg) // RULE4
        else $error("pin not gated");

    // One-cycle reset request
    a_reset_single: assert property (expiry_internal_reset |=> !expiry_internal_reset) // RULE5
        else $error("reset too long");

    // Idle read data is zero
    a_read_idle: assert property (!bus_req.rd |=> rd_data == 32'h0) // RULE12
        else $error("read data not cleared");

    // Readback, keys as zero
    a_clock_readback: assert property ( // RULE9
        bus_req.rd && bus_req.addr == kwdt_pkg::OFF_CLOCK_MODE |=> rd_data == {26'h0, $past(clkcfg_reg)})
        else $error("clock read wrong");

    a_status_readback: assert property ( // RULE14
        bus_req.rd && bus_req.addr == kwdt_pkg::OFF_EXPIRY_STATUS |=> rd_data == {31'h0, $past(expiry_flag_reg)})
        else $error("status read wrong");

    // Flag and counter
    a_flag_clear: assert property (restart |=> !expiry_flag_reg) // RULE14
        else $error("flag kept");

    a_zero_hold: assert property (count_reg == 16'h0000 && !restart |=> count_reg == 16'h0000) // RULE16
        else $error("counter left zero");

    // Event status and level
    a_event_set: assert property (expire |=> irq_status_reg[kwdt_pkg::EVT_EXPIRY])
        else $error("no event");

    a_irq_level: assert property (irq == |(irq_status_reg & irq_mask_reg))
        else $error("irq level wrong");

endmodule : kwdt_top

//--- bench/kwdt_expiry_sink.sv
// Model of the reset logic and interrupt controller that consume the expiry outputs.
// Assumes registered outputs on clk and a synchronous active-high reset.
`timescale 1ns/1ns
module kwdt_expiry_sink (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Expiry outputs of the watchdog
    input  wire logic expiry_internal_reset,
    input  wire logic expiry_irq_pulse,
    input  wire logic expiry_pin_n,
    // Observations for the bench
    output int        reset_cycles,
    output int        irq_cycles,
    output int        pin_low_run,
    output int        pin_pulses
);
    // ==========================================================
    // Pulse observation
    int run;

    // Counts high cycles of each request and measures every pin pulse
    always_ff @(posedge clk) begin
        if (rst) begin
            reset_cycles <= 0;
            irq_cycles   <= 0;
            pin_low_run  <= 0;
            pin_pulses   <= 0;
            run          <= 0;
        end else begin
            if (expiry_internal_reset === 1'b1) reset_cycles <= reset_cycles + 1;
            if (expiry_irq_pulse === 1'b1) irq_cycles <= irq_cycles + 1;
            if (expiry_pin_n !== 1'b1) begin
                run <= run + 1;
            end else if (run != 0) begin
                pin_low_run <= run; // Width of the finished pulse
                pin_pulses  <= pin_pulses + 1;
                run         <= 0;
            end
        end
    end
endmodule : kwdt_expiry_sink

//--- bench/kwdt_top_tb.sv
// Self-checking bench of the keyed watchdog timer.
// Assumes the design package is compiled first and a 20 MHz clock.
`timescale 1ns/1ns
module kwdt_top_tb;
    // ==========================================================
    // Signals
    logic                    clk;
    logic                    rst;
    kwdt_pkg::kwdt_bus_req_t bus_req;
    logic [31:0]             rd_data;
    logic                    expiry_internal_reset;
    logic                    expiry_irq_pulse;
    logic                    expiry_pin_n;
    logic                    irq;
    int                      reset_cycles;
    int                      irq_cycles;
    int                      pin_low_run;
    int                      pin_pulses;
    int                      errors = 0;
    int                      total_checks = 0;
    logic [31:0]             rv;

    kwdt_top i_dut (
        .clk                   (clk),
        .rst                   (rst),
        .bus_req               (bus_req),
        .rd_data               (rd_data),
        .expiry_internal_reset (expiry_internal_reset),
        .expiry_irq_pulse      (expiry_irq_pulse),
        .expiry_pin_n          (expiry_pin_n),
        .irq                   (irq)
    );

    kwdt_expiry_sink i_sink (
        .clk                   (clk),
        .rst                   (rst),
        .expiry_internal_reset (expiry_internal_reset),
        .expiry_irq_pulse      (expiry_irq_pulse),
        .expiry_pin_n          (expiry_pin_n),
        .reset_cycles          (reset_cycles),
        .irq_cycles            (irq_cycles),
        .pin_low_run           (pin_low_run),
        .pin_pulses            (pin_pulses)
    );

    // 50 ns clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // ==========================================================
    // Shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus_req <= '0;
    endtask : bus_write

    task automatic read_check(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus_req <= '0;
        @(negedge clk);
        check(rd_data, exp);
    endtask : read_check

    task automatic summarize;
        $display("checks=%0d errors=%0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : summarize

    // ==========================================================
    // Scenarios
    task automatic test_reset_map;
        check(expiry_pin_n, 32'h1);
        read_check(kwdt_pkg::OFF_OVERFLOW_MODE, 32'h0);
        read_check(kwdt_pkg::OFF_CLOCK_MODE, 32'h0);
        read_check(kwdt_pkg::OFF_RESTART_CONTROL, 32'h0);
        read_check(kwdt_pkg::OFF_EXPIRY_STATUS, 32'h0);
        read_check(8'h20, 32'h0);
    endtask : test_reset_map

    task automatic test_mode_keys;
        bus_write(kwdt_pkg::OFF_OVERFLOW_MODE, 32'h0000_2335);
        read_check(kwdt_pkg::OFF_OVERFLOW_MODE, 32'h0);
        read_check(kwdt_pkg::OFF_IRQ_STATUS, 32'h2);
        // Key alone, then control bits alone
        bus_write(kwdt_pkg::OFF_OVERFLOW_MODE, 32'h0000_2340);
        bus_write(kwdt_pkg::OFF_OVERFLOW_MODE, 32'h0000_000f);
        read_check(kwdt_pkg::OFF_OVERFLOW_MODE, 32'h0);
        for (int i = 0; i < 4; i++) begin
            bus_write(kwdt_pkg::OFF_OVERFLOW_MODE, {16'h0, 12'h234, 4'h1 << i});
            read_check(kwdt_pkg::OFF_OVERFLOW_MODE, {28'h0, 4'h1 << i});
        end
        bus_write(kwdt_pkg::OFF_OVERFLOW_MODE, 32'h0000_2340);
    endtask : test_mode_keys

    task automatic test_clock_keys;
        logic [3:0] nib;
        for (int s = 0; s < 4; s++) begin
            nib = 4'h5 ^ 4'(s * 3);
            bus_write(kwdt_pkg::OFF_CLOCK_MODE, {16'h0, 9'h06e, 1'b0, nib, 2'(s)});
            read_check(kwdt_pkg::OFF_CLOCK_MODE, {26'h0, nib, 2'(s)});
        end
        bus_write(kwdt_pkg::OFF_CLOCK_MODE, {16'h0, 9'h06f, 7'h00});
        read_check(kwdt_pkg::OFF_CLOCK_MODE, {26'h0, nib, 2'h3});
        bus_write(kwdt_pkg::OFF_CLOCK_MODE, 32'h0000_3700);
        read_check(kwdt_pkg::OFF_CLOCK_MODE, 32'h0);
    endtask : test_clock_keys

    // Key fault through the mask
    task automatic test_irq_mask;
        bus_write(kwdt_pkg::OFF_IRQ_MASK, 32'h2);
        repeat (2) @(negedge clk);
        check(irq, 32'h1);
        bus_write(kwdt_pkg::OFF_IRQ_MASK, 32'h0);
        repeat (2) @(negedge clk);
        check(irq, 32'h0);
        bus_write(kwdt_pkg::OFF_IRQ_STATUS, 32'h2);
        read_check(kwdt_pkg::OFF_IRQ_STATUS, 32'h0);
        bus_write(kwdt_pkg::OFF_IRQ_MASK, 32'h3);
        read_check(kwdt_pkg::OFF_IRQ_MASK, 32'h3);
        check(irq, 32'h0);
    endtask : test_irq_mask

    task automatic test_disabled;
        bus_write(kwdt_pkg::OFF_OVERFLOW_MODE, 32'h0000_234e);
        bus_write(kwdt_pkg::OFF_RESTART_CONTROL, 32'h0000_c071);
        repeat (300) @(posedge clk);
        check(reset_cycles + irq_cycles + pin_pulses, 32'h0);
        read_check(kwdt_pkg::OFF_EXPIRY_STATUS, 32'h0);
    endtask : test_disabled

    task automatic test_expiry;
        int n;
        int exp_n;
        exp_n = 4095 * int'(kwdt_pkg::DIV_SEL0);
        bus_write(kwdt_pkg::OFF_OVERFLOW_MODE, 32'h0000_234f);
        bus_write(kwdt_pkg::OFF_RESTART_CONTROL, 32'h0000_c071);
        for (n = 0; n < 140000 && expiry_internal_reset !== 1'b1; n++) @(negedge clk);
        check(32'(n >= exp_n - 4 && n <= exp_n + 4), 32'h1);
        check(expiry_irq_pulse, 32'h1);
        repeat (20) @(negedge clk);
        check(irq, 32'h1);
        check(reset_cycles, 32'h1);
        check(irq_cycles, 32'h1);
        check(pin_low_run, 32'h8);
        read_check(kwdt_pkg::OFF_EXPIRY_STATUS, 32'h1);
        repeat (200) @(posedge clk);
        check(pin_pulses + reset_cycles, 32'h2);
        bus_write(kwdt_pkg::OFF_RESTART_CONTROL, 32'h0000_c070);
        read_check(kwdt_pkg::OFF_EXPIRY_STATUS, 32'h1);
        bus_write(kwdt_pkg::OFF_IRQ_STATUS, 32'h1);
        repeat (2) @(negedge clk);
        check(irq, 32'h0);
        bus_write(kwdt_pkg::OFF_RESTART_CONTROL, 32'h0000_c071);
        read_check(kwdt_pkg::OFF_EXPIRY_STATUS, 32'h0);
        bus_write(kwdt_pkg::OFF_OVERFLOW_MODE, 32'h0000_2340);
    endtask : test_expiry

    // ==========================================================
    // Main sequence
    initial begin
        rst     = 1'b1;
        bus_req = '0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        @(negedge clk);
        test_reset_map();
        test_mode_keys();
        test_clock_keys();
        test_irq_mask();
        test_disabled();
        test_expiry();
        summarize();
    end

    // Hang guard sized above the one long expiry run
    initial begin
        #(200000 * 50);
        errors++;
        summarize();
    end
endmodule : kwdt_top_tb
